// ==== rtl/sfs_status_reg.sv ====
/*
 * Status register of a serial flash: the SPI command front end for the
 * write-enable, write-disable, read-status and write-status commands,
 * and the status fields themselves.
 * Assumes the SPI pins are asynchronous to ref_clk and slow enough to be
 * oversampled (mode 0), and that the array engine sits on ref_clk.
 */
// What this block does
// - Write-status changes only lock and protect bits.
// - Bit 0 shows busy while operation runs.
// - Bit 1 shows the write-enable latch.
// - Reserved bits 6 and 3 read zero.
// - Lock plus asserted wp freezes array protect.
// - Protect lock clears at power-up.
// - Lock writable freely with wp deasserted.
// - Lock clear under wp: ignore, clear latch.
// - Bit 5 set when program/erase failed.
// - Error refreshed per operation, never on abort.
// - Bit 4 mirrors the wp pin level.
// - Array protect one blocks all program/erase.
// - Latch zero rejects write-type commands.
// - Latch clears at power-up and reset.
// - Latch clears when write operations end.
// - Partial or unknown opcode keeps the latch.
// - Opcode 01h then one byte; extras ignored.
// - Commit lock/protect at chip-select rise.
// - Decision uses prior lock and sampled wp.
// - Unaligned or short frame aborts, clears latch.
// - Opcode 05h streams live status, MSB first.
`timescale 1ns/1ps
`include "sfs_cfg.svh"

module sfs_status_reg
  import sfs_pkg::*;
(
  input  wire logic        ref_clk,        // System clock, 50 MHz.
  input  wire logic        sys_rst,        // Synchronous reset, high.
  input  wire logic        spi_cs_n,       // Chip select pin, low active.
  input  wire logic        spi_sck,        // Serial clock pin.
  input  wire logic        spi_si,         // Serial data in pin.
  input  wire logic        wp_n,           // Write-protect pin, low active.
  input  wire logic        op_busy,        // Engine running, same clock.
  input  wire logic        op_done,        // Engine finished, pulse.
  input  wire logic        op_fail,        // Failure with op_done.
  input  wire logic        op_wel_clr,     // Engine ended or aborted.
  output sfs_status_t      status_byte_q,  // Live status byte.
  output logic             prog_ok_q,      // Array may be written.
  output logic             spi_so_q,       // Serial data out.
  output logic             spi_so_oe_q     // Drive enable of data out.
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pin_m_q;   // First stage: cs, sck, si, wp.
  logic [3:0] pin_s_q;   // Second stage, the only stage logic reads.
  logic       cs_d_q;    // Delayed synchronised chip select.
  logic       sck_d_q;   // Delayed synchronised serial clock.
  logic       cs_s;      // Synchronised chip select, low active.
  logic       sck_s;     // Synchronised serial clock.
  logic       si_s;      // Synchronised data in.
  logic       wp_s;      // Synchronised wp, low means asserted.

  // Every pin passes two flops; only the second stage fans out.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // Idle levels, so no false serial clock edge follows a reset.
      pin_m_q <= `SFS_PIN_IDLE;
      pin_s_q <= `SFS_PIN_IDLE;
    end else begin
      pin_m_q <= {spi_cs_n, spi_sck, spi_si, wp_n};
      pin_s_q <= pin_m_q;
    end
  end

  assign cs_s  = pin_s_q[3];
  assign sck_s = pin_s_q[2];
  assign si_s  = pin_s_q[1];
  assign wp_s  = pin_s_q[0];

  // Edge detectors look at the second stage and its delayed copy.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cs_d_q  <= 1'b1;
      sck_d_q <= 1'b0;
    end else begin
      cs_d_q  <= cs_s;
      sck_d_q <= sck_s;
    end
  end

  logic cs_rise;   // Frame ends.
  logic sck_rise;  // Input sample point.
  logic sck_fall;  // Output launch point.

  assign cs_rise  = cs_s & ~cs_d_q;
  assign sck_rise = ~cs_s & sck_s & ~sck_d_q;
  assign sck_fall = ~cs_s & ~sck_s & sck_d_q;

  // ----------------------------------------------------------------------
  // Serial shifter and frame decoder
  // ----------------------------------------------------------------------
  logic [7:0] sh_q;        // Input shift register.
  logic [2:0] bit_q;       // Bits of the current byte so far.
  logic [7:0] byte_in;     // Byte completed on this rising edge.
  logic       byte_done;   // Eighth bit sampled now.
  sfs_phase_t phase_q;     // Phase of the frame.
  sfs_cmd_t   cmd_q;       // Command decoded from a full opcode.
  sfs_wrsr_t  shadow_q;    // Pending write-status values.
  logic       data_ok_q;   // Full data byte of write-status seen.
  logic       aligned;     // Frame stands on a byte boundary.

  assign byte_in   = {sh_q[6:0], si_s};
  assign byte_done = sck_rise && (bit_q == `SFS_BIT_LAST);
  assign aligned   = (bit_q == `SFS_BIT_FIRST);

  // Bits shift in on the rising serial clock; the count resets per frame.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || cs_s) begin
      sh_q  <= 8'h00;
      bit_q <= 3'h0;
    end else if (sck_rise) begin
      sh_q  <= byte_in;
      bit_q <= bit_q + 3'h1;
    end
  end

  // Phase machine. An unknown opcode leaves cmd at none, so the frame end
  // does nothing to the latch.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || cs_s) begin
      phase_q <= PH_OPCODE;
      cmd_q   <= CMD_NONE;
    end else if (byte_done) begin
      case (phase_q)
        PH_OPCODE: begin
          case (byte_in)
            `SFS_OP_WRSR: begin
              cmd_q   <= CMD_WRSR;
              phase_q <= PH_WRSR_DATA;
            end
            `SFS_OP_RDSR: begin
              cmd_q   <= CMD_RDSR;
              phase_q <= PH_RDSR;
            end
            `SFS_OP_WREN: begin
              cmd_q   <= CMD_WREN;
              phase_q <= PH_SKIP;
            end
            `SFS_OP_WRDI: begin
              cmd_q   <= CMD_WRDI;
              phase_q <= PH_SKIP;
            end
            default: begin
              cmd_q   <= CMD_NONE;
              phase_q <= PH_SKIP;
            end
          endcase
        end
        PH_WRSR_DATA: phase_q <= PH_WRSR_TAIL;
        default:      phase_q <= phase_q;
      endcase
    end
  end

  // Only bits 7 and 2 of the data byte are kept; later bytes are ignored.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || cs_s) begin
      shadow_q  <= '0;
      data_ok_q <= 1'b0;
    end else if (byte_done && phase_q == PH_WRSR_DATA) begin
      shadow_q  <= '{lock: byte_in[7], prot: byte_in[2]};
      data_ok_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Write-status decision at the frame end
  // ----------------------------------------------------------------------
  logic wr_end;     // Write-status frame ended with the latch set.
  logic wr_good;    // Full byte, byte aligned.
  logic wp_on;      // Wp pin asserted, as sampled now.
  logic lock_ign;   // Attempt to clear the lock under wp.
  logic prot_frz;   // Array protect frozen by lock and wp.
  logic lock_q;     // Protect lock.
  logic prot_q;     // Array protect.
  logic wel_q;      // Write-enable latch.

  // The live latch gates the commit, not its registered status copy.
  assign wr_end   = cs_rise && cmd_q == CMD_WRSR && wel_q;
  assign wr_good  = data_ok_q && aligned;
  assign wp_on    = ~wp_s;
  assign lock_ign = wp_on && lock_q && !shadow_q.lock;
  assign prot_frz = wp_on && lock_q;

  // Prior lock and the sampled pin decide; nothing else may change here.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_q <= `SFS_LOCK_RST;
      prot_q <= `SFS_BP_RST;
    end else if (wr_end && wr_good && !lock_ign) begin
      lock_q <= shadow_q.lock;
      if (!prot_frz) begin
        prot_q <= shadow_q.prot;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write-enable latch
  // ----------------------------------------------------------------------
  logic wel_set;    // Aligned write-enable frame end.
  logic wel_clr;    // Any clearing event.

  assign wel_set = cs_rise && aligned && cmd_q == CMD_WREN;
  assign wel_clr = op_wel_clr ||
                   (cs_rise && cmd_q == CMD_WRSR) ||
                   (cs_rise && aligned && cmd_q == CMD_WRDI);

  // A set in the same cycle as a clear wins, so no enable is lost.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wel_q <= `SFS_WEL_RST;
    end else if (wel_set) begin
      wel_q <= 1'b1;
    end else if (wel_clr) begin
      wel_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Error flag and busy
  // ----------------------------------------------------------------------
  logic epe_q;      // Program or erase error.

  // Aborted operations raise no op_done, so they never touch the flag.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      epe_q <= `SFS_EPE_RST;
    end else if (op_done) begin
      epe_q <= op_fail;
    end
  end

  // ----------------------------------------------------------------------
  // Status byte and array permission outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_byte_q <= '0;
      prog_ok_q     <= 1'b0;
    end else begin
      status_byte_q.protect_lock       <= lock_q;
      status_byte_q.reserved_bit6      <= `SFS_RSV_VAL;
      status_byte_q.prog_erase_error   <= epe_q;
      status_byte_q.wp_pin_mirror      <= wp_s;
      status_byte_q.reserved_bit3      <= `SFS_RSV_VAL;
      status_byte_q.array_protect      <= prot_q;
      status_byte_q.write_enable_latch <= wel_q;
      status_byte_q.busy_flag          <= op_busy;
      prog_ok_q <= wel_q && !prot_q;
    end
  end

  // ----------------------------------------------------------------------
  // Read-status serial output
  // ----------------------------------------------------------------------
  logic [7:0] snap_q;  // Byte being shifted out.
  logic [2:0] out_q;   // Next bit index, counted from bit 7.

  // A fresh snapshot is taken at each byte start, so polling sees the
  // busy flag fall without restarting the command.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || cs_s || phase_q != PH_RDSR) begin
      snap_q      <= 8'h00;
      out_q       <= 3'h0;
      spi_so_q    <= 1'b0;
      spi_so_oe_q <= 1'b0;
    end else begin
      spi_so_oe_q <= 1'b1;
      if (sck_fall) begin
        out_q <= out_q + 3'h1;
        if (out_q == `SFS_BIT_FIRST) begin
          snap_q   <= status_byte_q;
          spi_so_q <= status_byte_q[7];
        end else begin
          spi_so_q <= snap_q[3'h7 - out_q];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  rsv_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !status_byte_q.reserved_bit6 && !status_byte_q.reserved_bit3)
    else $error("reserved status bit not zero");

  wp_mirror_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $past(sys_rst, 4) == 1'b0 |->
    status_byte_q.wp_pin_mirror == $past(wp_n, 3))
    else $error("wp mirror does not follow pin");

  busy_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 status_byte_q.busy_flag == $past(op_busy))
    else $error("busy bit does not follow engine");

  rst_clear_a: assert property (@(posedge ref_clk)
    sys_rst |=> !lock_q && !wel_q && !prot_q)
    else $error("reset left lock or latch set");

  wel_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cs_rise && cmd_q == CMD_WRSR && !wel_q |=>
    $stable(lock_q) && $stable(prot_q))
    else $error("write-status acted without latch");

  prot_freeze_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cs_rise && lock_q && !wp_s |=> $stable(prot_q))
    else $error("array protect changed while frozen");

  lock_ignore_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_end && lock_ign && !wel_set |=> lock_q && !wel_q)
    else $error("lock clear under wp not ignored");

  wrsr_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_end && !wr_good |=>
    $stable(lock_q) && $stable(prot_q) ##1 !status_byte_q.write_enable_latch)
    else $error("short write-status frame not aborted");

  wrsr_commit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_end && wr_good && wp_s |=>
    lock_q == $past(shadow_q.lock) && prot_q == $past(shadow_q.prot)
    && !wel_q)
    else $error("write-status commit wrong");

  epe_update_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_done |=> epe_q == $past(op_fail) ##1
    status_byte_q.prog_erase_error == $past(epe_q))
    else $error("error flag not refreshed");

  opc_partial_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cs_rise && cmd_q == CMD_NONE && !op_wel_clr |=> $stable(wel_q))
    else $error("latch changed on partial opcode");

  prot_block_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    prot_q |=> !prog_ok_q)
    else $error("array writable while protected");

  wrsr_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    wr_end && wr_good);
  lock_ign_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    wr_end && lock_ign);
  rdsr_rep_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    sck_fall && phase_q == PH_RDSR && out_q == 3'h7 ##[1:400]
    sck_fall && out_q == 3'h0);

endmodule

// ==== include/sfs_cfg.svh ====
/*
 * Constants of the serial flash status register block: command opcodes
 * and reset values of the status fields.
 * Assumes it is included by bare name from the design and the bench.
 */
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define SFS_OP_WRSR      8'h01
`define SFS_OP_RDSR      8'h05
`define SFS_OP_WREN      8'h06
`define SFS_OP_WRDI      8'h04

// ----------------------------------------------------------------------
// Reset values and field layout helpers
// ----------------------------------------------------------------------
`define SFS_LOCK_RST     1'b0
`define SFS_BP_RST       1'b0
`define SFS_WEL_RST      1'b0
`define SFS_EPE_RST      1'b0
`define SFS_RSV_VAL      1'b0
`define SFS_BIT_LAST     3'h7
`define SFS_BIT_FIRST    3'h0
// Idle pin levels {cs_n, sck, si, wp_n}: deselected, clock low, wp off.
`define SFS_PIN_IDLE     4'hB

`endif

// ==== include/sfs_pkg.sv ====
/*
 * Types of the serial flash status register block.
 * Assumes sfs_cfg.svh is on the include path.
 */
package sfs_pkg;

  // ----------------------------------------------------------------------
  // Status byte layout, bit 7 first.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic protect_lock;       // Freezes array_protect while wp asserted.
    logic reserved_bit6;      // Always reads zero.
    logic prog_erase_error;   // Last program or erase failed.
    logic wp_pin_mirror;      // Zero while the wp pin is asserted.
    logic reserved_bit3;      // Always reads zero.
    logic array_protect;      // Whole array protected when one.
    logic write_enable_latch; // Writes enabled when one.
    logic busy_flag;          // Self-timed operation running.
  } sfs_status_t;

  // Pending values captured from the write-status data byte.
  typedef struct packed {
    logic lock;
    logic prot;
  } sfs_wrsr_t;

  // Recognised commands of this block.
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_WREN,
    CMD_WRDI,
    CMD_WRSR,
    CMD_RDSR
  } sfs_cmd_t;

  // Phase of the current chip-select frame.
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_WRSR_DATA,
    PH_WRSR_TAIL,
    PH_RDSR,
    PH_SKIP
  } sfs_phase_t;

endpackage

// ==== sim/sfs_host_model.sv ====
/*
 * Behavioural SPI host that talks to the flash status block in mode 0.
 * Assumes its tasks are called from the bench at ref_clk falling edges.
 */
`timescale 1ns/1ps

module sfs_host_model (
  input  wire logic ref_clk,  // Bench clock; pins change on its fall.
  input  wire logic spi_so,   // Resolved serial data pin from device.
  output logic      spi_cs_n, // Chip select, low active.
  output logic      spi_sck,  // Serial clock, stands low between frames.
  output logic      spi_si    // Serial data towards the device.
);
  // ----------------------------------------------------------------------
  // State of the host
  // ----------------------------------------------------------------------
  int half = 4; // Half sck period in ref_clk cycles; raise it to go slow.

  // Idle pins at time zero so the device never sees an unknown frame.
  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_si   = 1'b1;
  end

  // ----------------------------------------------------------------------
  // One chip-select frame
  // ----------------------------------------------------------------------
  // Sends nbits of tx from bit 31 down; SO is sampled just before each
  // rising sck edge, so samples from bit 8 onward hold the answer.
  task automatic xfer(input  logic [31:0] tx,
                      input  int          nbits,
                      output logic [31:0] rx);
    rx = 32'h0;
    spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_si = tx[31-i];
      repeat (half) @(negedge ref_clk);
      rx = {rx[30:0], spi_so};
      spi_sck = 1'b1;
      repeat (half) @(negedge ref_clk);
      spi_sck = 1'b0;
    end
    repeat (half) @(negedge ref_clk);
    spi_cs_n = 1'b1;
    // A released line must not keep its last value, so flip it.
    spi_si = ~spi_si;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// ==== sim/tb.sv ====
/*
 * Self-checking bench of the flash status block: SPI frames from the
 * host model, engine pulses and write-protect pin changes.
 * Assumes sfs_pkg and sfs_cfg.svh are compiled and on the include path.
 */
`timescale 1ns/1ps
`include "sfs_cfg.svh"

module tb;
  import sfs_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        ref_clk    = 1'b0; // 50 MHz bench clock.
  logic        sys_rst    = 1'b1; // Reset, held at start.
  logic        wp_n       = 1'b1; // Write-protect pin, deasserted.
  logic        op_busy    = 1'b0; // Engine busy level.
  logic        op_done    = 1'b0; // Engine completion pulse.
  logic        op_fail    = 1'b0; // Failure qualifier of op_done.
  logic        op_wel_clr = 1'b0; // Engine latch clear pulse.
  logic        spi_cs_n;          // Host chip select.
  logic        spi_sck;           // Host serial clock.
  logic        spi_si;            // Host serial data.
  logic        so_pin;            // Resolved SO wire.
  logic        so_hold_n  = 1'b0; // Inverse of last driven SO bit.
  sfs_status_t status_byte_q;     // Live status from the device.
  logic        prog_ok_q;         // Array write permission.
  logic        spi_so_q;          // Device SO data.
  logic        spi_so_oe_q;       // Device SO drive enable.
  logic [31:0] rx;                // Bits gathered by the host.
  int          fail_count = 0;    // Mismatches seen.
  int          compares   = 0;    // Comparisons made.

  always #10 ref_clk = ~ref_clk;

  // Undriven SO has no pull, so it shows the inverse of its last value.
  assign so_pin = spi_so_oe_q ? spi_so_q : so_hold_n;
  always @(posedge ref_clk) if (spi_so_oe_q) so_hold_n <= ~spi_so_q;

  // ----------------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------------
  sfs_status_reg u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_si(spi_si), .wp_n(wp_n), .op_busy(op_busy),
    .op_done(op_done), .op_fail(op_fail), .op_wel_clr(op_wel_clr),
    .status_byte_q(status_byte_q), .prog_ok_q(prog_ok_q),
    .spi_so_q(spi_so_q), .spi_so_oe_q(spi_so_oe_q));

  sfs_host_model u_host (
    .ref_clk(ref_clk), .spi_so(so_pin), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_si(spi_si));

  // ----------------------------------------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------------------------------------
  task automatic chk_byte(input string nm, input logic [7:0] exp,
                          input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // Sends one command frame of nbits, left aligned in tx.
  task automatic cmd(input logic [31:0] tx, input int nbits);
    u_host.xfer(tx, nbits, rx);
  endtask

  task automatic stat(input logic [7:0] exp);
    chk_byte("status_byte_q", exp, status_byte_q);
  endtask

  // Write-enable always precedes a write-status frame from a sane host.
  task automatic wren;
    cmd({`SFS_OP_WREN, 24'h0}, 8);
  endtask

  // One-cycle engine strobe, then room for the status to settle.
  task automatic pulse(input logic d, input logic f, input logic w);
    op_done    = d;
    op_fail    = f;
    op_wel_clr = w;
    @(negedge ref_clk);
    {op_done, op_fail, op_wel_clr} = 3'h0;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard: a run that outlives this bound is a failure.
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    stat(8'h10);
    chk_bit("prog_ok_q", 1'b0, prog_ok_q);
    cmd({`SFS_OP_RDSR, 24'h0}, 24);
    chk_byte("so_byte", 8'h10, rx[15:8]);
    chk_bit("spi_so_oe_q", 1'b0, spi_so_oe_q);
    wren();
    stat(8'h12);
    chk_bit("prog_ok_q", 1'b1, prog_ok_q);
    cmd({`SFS_OP_WRSR, 8'hFF, 16'h0}, 16);
    stat(8'h94);
    chk_bit("prog_ok_q", 1'b0, prog_ok_q);
    // Assert the pin: lock now freezes protect and refuses its own clear.
    wp_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    stat(8'h84);
    wren();
    cmd({`SFS_OP_WRSR, 8'h00, 16'h0}, 16);
    stat(8'h84);
    wren();
    cmd({`SFS_OP_WRSR, 8'h80, 16'h0}, 16);
    stat(8'h84);
    wp_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    wren();
    cmd({`SFS_OP_WRSR, 8'h00, 16'h0}, 16);
    stat(8'h10);
    cmd({`SFS_OP_WRSR, 8'h84, 16'h0}, 16);
    stat(8'h10);
    // Aborted frames: partial and unknown opcodes keep the latch.
    wren();
    cmd({`SFS_OP_WRSR, 24'h0}, 5);
    stat(8'h12);
    cmd({8'hA5, 24'h0}, 8);
    stat(8'h12);
    cmd({`SFS_OP_WRSR, 8'h84, 16'h0}, 12);
    stat(8'h10);
    wren();
    cmd({`SFS_OP_WRSR, 24'h0}, 8);
    stat(8'h10);
    // Slow host, extra bytes after the data byte are dropped.
    wren();
    u_host.half = 8;
    cmd({`SFS_OP_WRSR, 8'h04, 8'hFF, 8'h00}, 32);
    u_host.half = 4;
    stat(8'h14);
    wren();
    cmd({`SFS_OP_WRDI, 24'h0}, 8);
    stat(8'h14);
    // Busy drops during a repeated status read; second byte is fresh.
    wren();
    op_busy = 1'b1;
    fork
      cmd({`SFS_OP_RDSR, 24'h0}, 24);
      begin
        repeat (100) @(negedge ref_clk);
        op_busy = 1'b0;
      end
    join
    chk_byte("so_byte", 8'h17, rx[15:8]);
    chk_byte("so_byte", 8'h16, rx[7:0]);
    pulse(1'b0, 1'b0, 1'b1);
    stat(8'h14);
    pulse(1'b1, 1'b1, 1'b0);
    stat(8'h34);
    pulse(1'b0, 1'b1, 1'b1);
    stat(8'h34);
    pulse(1'b1, 1'b0, 1'b0);
    stat(8'h14);
    // Reset in mid-run returns protect and latch to defaults; lock is already clear.
    wren();
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    stat(8'h10);
    end_of_test();
  end
endmodule
